/* File: pkg/pic_pkg.sv */
// Package of constants for the position indicator control block.
// Assumes a single 25 MHz system clock and power cycle as reset.
package pic_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TX_PERIOD_MS = 250;
  localparam int unsigned TX_PERIOD_CYC = CLK_HZ / 1000 * TX_PERIOD_MS;
  localparam int unsigned ACK_HOLD_MS = 1000;
  localparam int unsigned ACK_HOLD_CYC = CLK_HZ / 1000 * ACK_HOLD_MS;
  localparam int unsigned MIN_CYC = CLK_HZ / 1000 * 60000;
  localparam int unsigned RADIO_OFF_MS = 10000;
  // ----------------------------------------------------------------
  // Parameter limits and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] UNIT_INCH = 3'h1;
  localparam logic [2:0] UNIT_MAX = 3'h4;
  localparam logic [2:0] DP_DEFAULT = 3'h2;
  localparam logic [2:0] DP_MAX = 3'h4;
  localparam logic [4:0] POWER_OFF_DEFAULT = 5'h01;
  localparam logic [16:0] SCALE_DEFAULT = 17'h02710;
  localparam logic [16:0] SCALE_MIN = 17'h00001;
  localparam logic [16:0] SCALE_MAX = 17'h1869f;
  localparam logic signed [31:0] VALUE_MAX = 32'sh0098967f;
  localparam logic [1:0] OFFSET_COUNT_DEFAULT = 2'h3;
  localparam logic [7:0] TARGET_NET_DEFAULT = 8'h01;
  localparam logic [7:0] TARGET_NODE_DEFAULT = 8'h00;
  localparam logic [6:0] RADIO_CHANNEL_DEFAULT = 7'h6a;
  localparam logic [2:0] PROTOCOL_MAX = 3'h4;
  localparam logic [3:0] CAL_LAST_STEP = 4'h4;
  localparam logic [3:0] CAL_ERR_MAX = 4'ha;
  localparam int unsigned SCALE_DIV = 10000;
  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PIC_FR_64, PIC_FR_32, PIC_FR_16, PIC_FR_DEC
  } pic_frac_t;
  typedef enum logic [1:0] {
    PIC_ST_CAL, PIC_ST_RUN, PIC_ST_SLEEP
  } pic_state_t;
endpackage

/* File: logic/pic_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; read data come from a register.
`timescale 1ns/1ns
module pic_fifo
  import pic_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
)
(
  input wire logic i_ref_clk, // System clock
  input wire logic i_rst_n, // Async reset, low
  input wire logic i_in_valid, // Write request
  output logic o_in_ready, // Not full
  input wire logic [WIDTH-1:0] i_in_data, // Write data
  output logic o_out_valid, // Not empty
  input wire logic i_out_ready, // Drain accepts
  output logic [WIDTH-1:0] o_out_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] count;
  wire do_wr = i_in_valid && o_in_ready;
  wire do_rd = o_out_valid && i_out_ready;
  wire [AW:0] next_count = count + {{AW{1'b0}}, do_wr}
    - {{AW{1'b0}}, do_rd};

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  // Flags registered from the next count so they stay honest
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
      count <= next_count;
      o_in_ready <= next_count != DEPTH[AW:0];
      o_out_valid <= next_count != '0;
    end
  end

  // Memory has no reset; head register tracks next read pointer
  always_ff @(posedge i_ref_clk)
  begin
    if (do_wr)
      mem[wr_ptr[AW-1:0]] <= i_in_data;
  end

  wire [AW:0] next_rd = do_rd ? rd_ptr + 1'b1 : rd_ptr;
  wire fwd = do_wr && (wr_ptr[AW-1:0] == next_rd[AW-1:0]);
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_out_data <= '0;
    else if (fwd)
      o_out_data <= i_in_data;
    else
      o_out_data <= mem[next_rd[AW-1:0]];
  end
endmodule

/* File: logic/pic_timer.sv */
// Down-counting interval timer giving a one-cycle expiry pulse.
// Assumes one clock; restart reloads the count.
`timescale 1ns/1ns
module pic_timer
  import pic_pkg::*;
#(
  parameter int unsigned COUNT = 1000
)
(
  input wire logic i_ref_clk, // System clock
  input wire logic i_rst_n, // Async reset, low
  input wire logic i_run, // Count while high
  input wire logic i_restart, // Reload to full count
  output logic o_tick // Expiry pulse
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LOAD = CW'(COUNT - 1);
  logic [CW-1:0] cnt;

  // Reload on restart, stop and reload when not running
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt <= LOAD;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= 1'b0;
      if (i_restart || !i_run)
        cnt <= LOAD;
      else if (cnt == '0)
      begin
        cnt <= LOAD;
        o_tick <= 1'b1;
      end
      else
        cnt <= cnt - 1'b1;
    end
  end
endmodule

/* File: logic/pic_control.sv */
// Control logic of a battery position indicator: parameters, calibration,
// operator functions and radio send requests.
// Assumes key inputs are debounced one-cycle pulses synchronous to clock.
`timescale 1ns/1ns
module pic_control
  import pic_pkg::*;
#(
  parameter int unsigned TX_CYC = TX_PERIOD_CYC,
  parameter int unsigned ACK_CYC = ACK_HOLD_CYC,
  parameter int unsigned MINUTE_CYC = MIN_CYC,
  parameter int FIFO_DEPTH = 16
)
(
  input wire logic i_ref_clk, // 25 MHz system clock
  input wire logic i_rst_n, // Power cycle reset, low
  // Keys at power-up and operator level
  input wire logic i_cal_key_held, // Calibration key at power-up
  input wire logic i_incabs_key_held, // Incr/abs key at power-up
  input wire logic i_key_set, // Set key pulse
  input wire logic i_key_incabs, // Incr/abs key pulse
  input wire logic i_key_offset, // Offset key pulse
  input wire logic i_key_func, // Function key pulse
  input wire logic i_key_ref, // Reference combination pulse
  // Sensor front end
  input wire logic signed [31:0] i_position, // Raw position counts
  input wire logic i_sensor_moved, // Movement detected pulse
  input wire logic i_cal_step, // Calibration step done pulse
  input wire logic i_cal_fail, // Calibration failed pulse
  input wire logic [3:0] i_cal_err_code, // Failure code 1..10
  // Parameter editing level
  input wire logic i_param_we, // Write parameter set
  input wire logic i_edit_negate, // Sign key on edited value
  input wire logic signed [31:0] i_edit_value, // Value being edited
  input wire logic i_edit_leave, // Leaving edit level pulse
  input wire logic i_tx_trigger, // 0 cyclic, 1 set key
  input wire logic i_direction, // 1 inverts counting
  input wire logic [2:0] i_unit_symbol_param, // Unit 0..4
  input wire logic [2:0] i_decimal_point_param, // Point 0..4
  input wire logic [4:0] i_power_off_time_param, // Minutes, 0 off
  input wire logic [2:0] i_key_lock_param, // Set, incabs, offset
  input wire logic [16:0] i_scale_factor_param, // Factor x10000
  input wire logic signed [31:0] i_reference_value_param, // Reference
  input wire logic signed [31:0] i_first_offset_param, // Offset 1
  input wire logic signed [31:0] i_second_offset_param, // Offset 2
  input wire logic signed [31:0] i_third_offset_param, // Offset 3
  input wire logic [1:0] i_offset_count_param, // Allowed offsets
  input wire logic [6:0] i_radio_channel_param, // Radio channel
  input wire logic [7:0] i_target_net_param, // Target net
  input wire logic [7:0] i_target_node_param, // Target node
  input wire logic [2:0] i_transmit_protocol_param, // 0 off, 1..4
  // Radio
  input wire logic i_radio_ack, // Receiver acknowledge pulse
  input wire logic i_radio_ready, // Radio accepts a frame
  output logic o_radio_valid, // Frame ready to send
  output logic [31:0] o_radio_value, // Display value to send
  output logic [2:0] o_radio_protocol, // Protocol of the frame
  output logic [6:0] o_radio_channel, // Channel latched at start
  output logic [7:0] o_radio_net, // Net latched at start
  output logic [7:0] o_radio_node, // Node latched at start
  // Display and status
  output logic signed [31:0] o_display_value, // Scaled display value
  output logic o_unit_inch, // Inch mode active
  output logic [2:0] o_unit_symbol, // Symbol code 0..4
  output logic [2:0] o_decimal_point, // Point, 0 in inch mode
  output logic [1:0] o_fraction_mode, // 64, 32, 16, decimal
  output logic o_incremental, // INC symbol, else ABS
  output logic [1:0] o_offset_icon, // 0 none, 1..3 offset
  output logic o_ack_icon, // Reception icon
  output logic o_calibrating, // Calibration running
  output logic [3:0] o_cal_step, // CAL step 0..4
  output logic [3:0] o_error_code, // Error code, 0 none
  output logic o_sleep, // Sleep mode
  output logic o_flash_write, // Store parameters pulse
  output logic signed [31:0] o_edit_result // Edited value after sign
);
  // ----------------------------------------------------------------
  // Parameter set
  // ----------------------------------------------------------------
  logic tx_trig, dir_inv;
  logic [2:0] unit_sym, dp, key_lock, protocol;
  logic [4:0] off_time;
  logic [16:0] scale;
  logic signed [31:0] ref_val, off1, off2, off3;
  logic [1:0] off_count;
  logic [6:0] chan_live;
  logic [7:0] net_live, node_live;
  logic load_defaults;

  function automatic logic signed [31:0] clip(input logic signed [31:0] v);
    if (v > VALUE_MAX)
      return VALUE_MAX;
    else if (v < -VALUE_MAX)
      return -VALUE_MAX;
    else
      return v;
  endfunction

  // Writes clamp to documented ranges, except protocol, which drops to 0. Reset already holds the factory
  // set, so the restore path only keeps a write out of its first cycle.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_trig <= 1'b0;
      dir_inv <= 1'b0;
      unit_sym <= '0;
      dp <= DP_DEFAULT;
      off_time <= POWER_OFF_DEFAULT;
      key_lock <= '0;
      scale <= SCALE_DEFAULT;
      ref_val <= '0;
      off1 <= '0;
      off2 <= '0;
      off3 <= '0;
      off_count <= OFFSET_COUNT_DEFAULT;
      chan_live <= RADIO_CHANNEL_DEFAULT;
      net_live <= TARGET_NET_DEFAULT;
      node_live <= TARGET_NODE_DEFAULT;
      protocol <= '0;
    end
    else if (i_param_we && !load_defaults)
    begin
      tx_trig <= i_tx_trigger;
      dir_inv <= i_direction;
      unit_sym <= (i_unit_symbol_param > UNIT_MAX) ? UNIT_MAX
        : i_unit_symbol_param;
      dp <= (i_decimal_point_param > DP_MAX) ? DP_MAX
        : i_decimal_point_param;
      off_time <= i_power_off_time_param;
      key_lock <= i_key_lock_param;
      scale <= (i_scale_factor_param > SCALE_MAX) ? SCALE_MAX
        : (i_scale_factor_param < SCALE_MIN) ? SCALE_MIN
        : i_scale_factor_param;
      ref_val <= clip(i_reference_value_param);
      off1 <= clip(i_first_offset_param);
      off2 <= clip(i_second_offset_param);
      off3 <= clip(i_third_offset_param);
      off_count <= i_offset_count_param;
      chan_live <= i_radio_channel_param;
      net_live <= i_target_net_param;
      node_live <= i_target_node_param;
      protocol <= (i_transmit_protocol_param > PROTOCOL_MAX) ? '0
        : i_transmit_protocol_param;
    end
  end

  // Radio addressing frozen once after reset release
  logic addr_taken;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      addr_taken <= 1'b0;
      o_radio_channel <= '0;
      o_radio_net <= '0;
      o_radio_node <= '0;
    end
    else if (!addr_taken)
    begin
      addr_taken <= 1'b1;
      o_radio_channel <= chan_live;
      o_radio_net <= net_live;
      o_radio_node <= node_live;
    end
  end

  // ----------------------------------------------------------------
  // Power-up paths and sleep
  // ----------------------------------------------------------------
  pic_state_t state;
  logic started, awake_evt, sleep_tick, minute_tick;
  logic [4:0] idle_min;
  wire any_key = i_key_set | i_key_incabs | i_key_offset | i_key_ref;
  assign awake_evt = i_sensor_moved | i_key_func;
  assign load_defaults = !started && i_incabs_key_held;

  pic_timer #(.COUNT(MINUTE_CYC)) u_minute (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_run(state == PIC_ST_RUN),
    .i_restart(awake_evt | any_key),
    .o_tick(minute_tick)
  );
  assign sleep_tick = minute_tick && off_time != '0
    && idle_min + 5'h01 >= off_time;

  // Straps caught on the first clock after release
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      started <= 1'b0;
      state <= PIC_ST_RUN;
      o_cal_step <= '0;
      o_error_code <= '0;
      idle_min <= '0;
    end
    else
    begin
      started <= 1'b1;
      case (state)
        PIC_ST_CAL:
        begin
          if (i_cal_fail)
          begin
            o_error_code <= (i_cal_err_code == '0) ? 4'h1
              : (i_cal_err_code > CAL_ERR_MAX) ? CAL_ERR_MAX
              : i_cal_err_code;
            state <= PIC_ST_RUN;
          end
          else if (i_cal_step)
          begin
            if (o_cal_step == CAL_LAST_STEP)
              state <= PIC_ST_RUN;
            else
              o_cal_step <= o_cal_step + 4'h1;
          end
        end
        PIC_ST_RUN:
        begin
          if (!started && (i_cal_key_held || i_incabs_key_held))
          begin
            state <= PIC_ST_CAL;
            o_cal_step <= '0;
          end
          else if (awake_evt || any_key)
            idle_min <= '0;
          else if (sleep_tick)
          begin
            state <= PIC_ST_SLEEP;
            idle_min <= '0;
          end
          else if (minute_tick)
            idle_min <= idle_min + 5'h01;
        end
        PIC_ST_SLEEP:
        begin
          if (awake_evt)
            state <= PIC_ST_RUN;
        end
        default: state <= PIC_ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Operator level
  // ----------------------------------------------------------------
  wire op = state == PIC_ST_RUN && started;
  wire key_set_ok = op && i_key_set && !key_lock[2];
  wire key_ia_ok = op && i_key_incabs && !key_lock[1];
  wire key_off_ok = op && i_key_offset && !key_lock[0];
  wire inch = unit_sym == UNIT_INCH;
  logic incr;
  logic [1:0] off_sel;
  logic signed [31:0] zero_pt;
  pic_frac_t frac;
  wire signed [31:0] pos_dir = dir_inv ? -i_position : i_position;
  wire signed [31:0] sel_off = (off_sel == 2'h1) ? off1
    : (off_sel == 2'h2) ? off2 : (off_sel == 2'h3) ? off3 : 32'sh0;
  wire signed [49:0] scaled = pos_dir * $signed({1'b0, scale});
  wire signed [31:0] disp_base = 32'(scaled / $signed(50'(SCALE_DIV)));
  wire signed [31:0] next_display = disp_base - zero_pt
    + (incr ? 32'sh0 : sel_off);
  wire [1:0] next_off = (off_sel >= off_count) ? 2'h0
    : off_sel + 2'h1;

  // Key handling; zero point set so the display shows the target
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      incr <= 1'b0;
      off_sel <= '0;
      zero_pt <= '0;
      frac <= PIC_FR_64;
    end
    else
    begin
      if (i_key_ref && op && (incr || off_sel == '0))
        zero_pt <= disp_base - ref_val;
      else if (key_ia_ok)
      begin
        incr <= !incr;
        if (!incr)
          zero_pt <= disp_base;
        else
          zero_pt <= '0;
      end
      if (key_off_ok && !incr)
        off_sel <= next_off;
      if (off_sel > off_count)
        off_sel <= '0;
      if (key_set_ok && inch)
        frac <= pic_frac_t'(frac + 2'h1);
    end
  end

  // Display outputs registered
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_display_value <= '0;
      o_unit_inch <= 1'b0;
      o_unit_symbol <= '0;
      o_decimal_point <= DP_DEFAULT;
      o_fraction_mode <= '0;
      o_incremental <= 1'b0;
      o_offset_icon <= '0;
      o_calibrating <= 1'b0;
      o_sleep <= 1'b0;
    end
    else
    begin
      o_display_value <= next_display;
      o_unit_inch <= inch;
      o_unit_symbol <= unit_sym;
      o_decimal_point <= inch ? 3'h0 : dp;
      o_fraction_mode <= inch ? frac : 2'h0;
      o_incremental <= incr;
      o_offset_icon <= incr ? 2'h0 : off_sel;
      o_calibrating <= state == PIC_ST_CAL;
      o_sleep <= state == PIC_ST_SLEEP;
    end
  end

  // ----------------------------------------------------------------
  // Radio send path
  // ----------------------------------------------------------------
  logic cyc_tick, ack_tick, fifo_ready, pending;
  pic_timer #(.COUNT(TX_CYC)) u_cyclic (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_run(op && !tx_trig),
    .i_restart(1'b0),
    .o_tick(cyc_tick)
  );
  // Sleep and protocol 0 block every request at the source
  wire tx_req = op && protocol != '0 && (tx_trig ? key_set_ok
    : cyc_tick);
  wire tx_push = tx_req && !pending && fifo_ready;

  // One request in flight; pending clears when the radio takes it
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pending <= 1'b0;
    else if (tx_push)
      pending <= 1'b1;
    else if (o_radio_valid && i_radio_ready)
      pending <= 1'b0;
  end

  logic [34:0] fifo_out;
  pic_fifo #(.WIDTH(35), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(tx_push),
    .o_in_ready(fifo_ready),
    .i_in_data({protocol, next_display}),
    .o_out_valid(o_radio_valid),
    .i_out_ready(i_radio_ready),
    .o_out_data(fifo_out)
  );
  assign o_radio_value = fifo_out[31:0];
  assign o_radio_protocol = fifo_out[34:32];

  pic_timer #(.COUNT(ACK_CYC)) u_ack (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_run(o_ack_icon),
    .i_restart(i_radio_ack),
    .o_tick(ack_tick)
  );
  // Acknowledge wins over expiry in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_ack_icon <= 1'b0;
    else if (i_radio_ack)
      o_ack_icon <= 1'b1;
    else if (ack_tick)
      o_ack_icon <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Editing helpers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_flash_write <= 1'b0;
      o_edit_result <= '0;
    end
    else
    begin
      o_flash_write <= i_edit_leave;
      o_edit_result <= (i_edit_negate && i_edit_value != '0)
        ? -i_edit_value : i_edit_value;
    end
  end
endmodule

/* File: tb/pic_sva.sv */
// Checker on the control block ports.
// Assumes a bind onto pic_control; one clock domain.
`timescale 1ns/1ns
module pic_sva
  import pic_pkg::*;
(
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic i_radio_ack, // Ack
  input wire logic i_radio_ready, // Ready
  input wire logic i_edit_leave, // Leave
  input wire logic o_radio_valid, // Valid
  input wire logic [31:0] o_radio_value, // Value
  input wire logic [6:0] o_radio_channel, // Channel
  input wire logic o_unit_inch, // Inch
  input wire logic [2:0] o_unit_symbol, // Symbol
  input wire logic [2:0] o_decimal_point, // Point
  input wire logic o_ack_icon, // Icon
  input wire logic [3:0] o_cal_step, // Step
  input wire logic [3:0] o_error_code, // Error
  input wire logic o_flash_write // Store
);
  // One domain; reset silences every check
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  chk_ack_lights_icon: assert property
    (i_radio_ack |=> o_ack_icon) else $error("icon not lit");
  chk_leave_stores: assert property
    (i_edit_leave |=> o_flash_write) else $error("no store");
  chk_inch_symbol: assert property
    (o_unit_inch == (o_unit_symbol == UNIT_INCH)) else $error("inch");
  chk_inch_point: assert property
    (o_unit_inch |-> o_decimal_point == 3'h0) else $error("point");
  chk_cal_range: assert property
    (o_cal_step <= CAL_LAST_STEP) else $error("cal step");
  chk_err_range: assert property
    (o_error_code <= CAL_ERR_MAX) else $error("error code");
  chk_frame_held: assert property
    (o_radio_valid && !i_radio_ready |=> o_radio_valid
      && $stable(o_radio_value)) else $error("frame lost");
  chk_channel_frozen: assert property
    ($past(i_rst_n, 2) |-> $stable(o_radio_channel)) else $error("chan");
endmodule

bind pic_control pic_sva u_sva (.*);

/* File: tb/pic_radio_rx.sv */
// Radio receiver model on the frame port.
// Assumes valid/ready; acks two cycles after each take.
`timescale 1ns/1ns
module pic_radio_rx (
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic i_valid, // Frame offered
  output logic o_ready, // Frame taken
  output logic o_ack, // Ack pulse
  output int o_frames // Frames taken
);
  logic [1:0] ack_pipe;
  // Stalls one cycle in four so back-pressure is exercised
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ready <= 1'b0;
      ack_pipe <= 2'h0;
      o_frames <= 0;
    end
    else
    begin
      o_ready <= ($urandom_range(3) != 0);
      ack_pipe <= {ack_pipe[0], i_valid && o_ready};
      o_frames <= o_frames + int'(i_valid && o_ready);
    end
  end
  assign o_ack = ack_pipe[1];
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the control block with a radio model.
// Assumes shortened timers and one-cycle key pulses.
`timescale 1ns/1ns
module testbench;
  import pic_pkg::*;
  localparam int TXC = 20;
  localparam logic [6:0] KS = 7'h40, KI = 7'h20, KO = 7'h10, KR = 7'h08;
  localparam logic [6:0] KL = 7'h04, KC = 7'h02, KM = 7'h01;
  logic i_ref_clk, i_rst_n, i_cal_key_held, i_incabs_key_held, i_key_set;
  logic i_key_incabs, i_key_offset, i_key_func, i_key_ref, i_sensor_moved;
  logic i_cal_step, i_cal_fail, i_param_we, i_edit_negate, i_edit_leave;
  logic i_tx_trigger, i_direction, i_radio_ack, i_radio_ready;
  logic o_radio_valid, o_unit_inch, o_incremental, o_ack_icon;
  logic o_calibrating, o_sleep, o_flash_write;
  logic signed [31:0] i_position, i_edit_value, i_reference_value_param, p;
  logic signed [31:0] i_first_offset_param, i_second_offset_param;
  logic signed [31:0] i_third_offset_param, o_display_value, o_edit_result;
  logic [3:0] i_cal_err_code, o_cal_step, o_error_code;
  logic [2:0] i_unit_symbol_param, i_decimal_point_param, i_key_lock_param, d;
  logic [2:0] i_transmit_protocol_param, o_radio_protocol, o_unit_symbol;
  logic [2:0] o_decimal_point;
  logic [4:0] i_power_off_time_param;
  logic [16:0] i_scale_factor_param;
  logic [1:0] i_offset_count_param, o_fraction_mode, o_offset_icon;
  logic [6:0] i_radio_channel_param, o_radio_channel;
  logic [7:0] i_target_net_param, i_target_node_param, o_radio_net;
  logic [7:0] o_radio_node;
  logic [31:0] o_radio_value;
  int errors = 0, tests_run = 0, frames, cyc = 0, f0;
  pic_control #(.TX_CYC(TXC), .ACK_CYC(50), .MINUTE_CYC(100)) uut (.*);
  pic_radio_rx rx (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_valid(o_radio_valid), .o_ready(i_radio_ready), .o_ack(i_radio_ack),
    .o_frames(frames));
  // Clock, and a cycle ceiling that cuts a hang short
  initial
  begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
      errors++;
    if (seen !== exp)
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
  endtask
  // Samples 2 ns after the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #2;
  endtask
  task automatic key(input logic [6:0] k);
    @(posedge i_ref_clk);
    {i_key_set, i_key_incabs, i_key_offset, i_key_ref} <= k[6:3];
    {i_edit_leave, i_cal_step, i_sensor_moved} <= k[2:0];
    @(posedge i_ref_clk);
    {i_key_set, i_key_incabs, i_key_offset, i_key_ref} <= '0;
    {i_edit_leave, i_cal_step, i_sensor_moved} <= '0;
    tick(3);
  endtask
  task automatic wr(input logic [2:0] u, dp, lk, pr, input logic tr, dr);
    @(posedge i_ref_clk);
    {i_unit_symbol_param, i_decimal_point_param} <= {u, dp};
    {i_key_lock_param, i_transmit_protocol_param} <= {lk, pr};
    {i_tx_trigger, i_direction, i_param_we} <= {tr, dr, 1'b1};
    @(posedge i_ref_clk);
    i_param_we <= 1'b0;
    tick(3);
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(32'h2b9e2966));
    p = $urandom_range(5000);
    i_position = p;
    i_reference_value_param = $urandom_range(9999);
    i_first_offset_param = $urandom_range(9999);
    {i_cal_key_held, i_incabs_key_held, i_key_set, i_key_incabs} = '0;
    {i_key_offset, i_key_func, i_key_ref, i_sensor_moved, i_cal_step} = '0;
    {i_cal_fail, i_param_we, i_edit_negate, i_edit_leave} = '0;
    {i_tx_trigger, i_direction, i_cal_err_code, i_edit_value} = '0;
    {i_second_offset_param, i_third_offset_param, i_key_lock_param} = '0;
    {i_unit_symbol_param, i_decimal_point_param, i_power_off_time_param} = '0;
    {i_transmit_protocol_param, i_radio_channel_param} = '0;
    {i_target_net_param, i_target_node_param} = 16'h5a77;
    {i_scale_factor_param, i_offset_count_param} = {17'h02710, 2'h1};
    i_rst_n = 1'b0;
    repeat (6) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    tick(3);
    chk(o_decimal_point, 3'h2);
    chk(o_radio_channel, 7'h6a);
    for (int u = 0; u < 5; u++)
    begin
      d = $urandom_range(4);
      wr(u, d, 0, 0, 0, 0);
      chk(o_unit_inch, u == 1);
      chk(o_decimal_point, (u == 1) ? 3'h0 : d);
      chk(o_display_value, p);
    end
    wr(0, 2, 0, 0, 0, 1);
    chk(o_display_value, -p);
    $display("units done");
    wr(1, 2, 0, 0, 0, 0);
    for (int i = 1; i < 5; i++)
    begin
      key(KS);
      chk(o_fraction_mode, i % 4);
    end
    wr(0, 2, 3'h2, 0, 0, 0);
    key(KI);
    chk(o_incremental, 1'b0);
    wr(0, 2, 0, 0, 0, 0);
    key(KI);
    chk(o_display_value, 0);
    key(KO);
    chk(o_offset_icon, 2'h0);
    key(KI);
    chk(o_incremental, 1'b0);
    key(KO);
    key(KR);
    chk(o_display_value, p + i_first_offset_param);
    key(KO);
    chk(o_offset_icon, 2'h0);
    key(KR);
    chk(o_display_value, i_reference_value_param);
    $display("keys done");
    for (int r = 1; r < 5; r++)
    begin
      wr(0, 2, 0, 0, 0, 0);
      tick(TXC);
      wr(0, 2, 0, r, 0, 0);
      for (int n = 0; n < 2 * TXC && o_radio_valid !== 1'b1; n++)
        tick(1);
      chk(o_radio_protocol, r);
      chk(o_radio_value, i_reference_value_param);
    end
    f0 = frames;
    tick(10 * TXC);
    chk((frames - f0) inside {[9:11]}, 1'b1);
    chk(o_ack_icon, 1'b1);
    chk(o_radio_net, 8'h01);
    wr(0, 2, 0, 0, 0, 0);
    tick(TXC);
    f0 = frames;
    tick(3 * TXC);
    chk(frames - f0, 0);
    chk(o_ack_icon, 1'b0);
    $display("cyclic done");
    wr(0, 2, 3'h4, 3'h2, 1, 0);
    key(KS);
    tick(3 * TXC);
    chk(frames - f0, 0);
    wr(0, 2, 0, 3'h2, 1, 0);
    key(KS);
    tick(4);
    chk(frames - f0, 1);
    key(KL);
    @(posedge i_ref_clk);
    {i_edit_negate, i_edit_value} <= {1'b1, p};
    tick(2);
    chk(o_edit_result, -p);
    $display("manual done");
    // Sleep after one idle minute; no send while asleep
    @(posedge i_ref_clk);
    i_power_off_time_param <= 5'h01;
    wr(0, 2, 0, 3'h2, 1, 0);
    tick(110);
    chk(o_sleep, 1'b1);
    key(KS);
    tick(4);
    chk(frames - f0, 1);
    key(KM);
    chk(o_sleep, 1'b0);
    // Second power-up with the calibration key held
    @(posedge i_ref_clk);
    {i_rst_n, i_cal_key_held} <= 2'b01;
    @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    tick(2);
    chk(o_calibrating, 1'b1);
    repeat (4) key(KC);
    chk(o_cal_step, CAL_LAST_STEP);
    key(KC);
    chk(o_calibrating, 1'b0);
    $display("power done");
    print_verdict();
  end
endmodule
